// File: src/apfs_pkg.sv
// apfs_pkg: register map, field layout, reset values and pin-route carrier
// for the analog port pin function select block.
// assumes a 32-bit AHB-Lite bus with each register on one aligned word.
package apfs_pkg;

  // register indices (byte address is four times the index)
  localparam logic [15:0] IDX_PORT2_DIRECTION   = 16'hff22;
  localparam logic [15:0] IDX_PORT7_DIRECTION   = 16'hff27;
  localparam logic [15:0] IDX_ANALOG_SEL_LO     = 16'hff2e;
  localparam logic [15:0] IDX_ANALOG_SEL_HI     = 16'hff2f;
  localparam logic [15:0] IDX_CONV_CHANNEL_SEL  = 16'hff30;
  localparam logic [15:0] IDX_AMPLIFIER_CONTROL = 16'hff31;
  localparam logic [15:0] IDX_COMPARATOR_ENABLE = 16'hff32;
  localparam logic [15:0] IDX_PIN_ROUTE_STATUS  = 16'hff33;

  // reset values
  localparam logic [7:0] RST_PORT2_DIRECTION  = 8'hff;
  localparam logic       RST_PORT7_PIN_DIR    = 1'h1;
  localparam logic [7:0] RST_ANALOG_SEL_LO    = 8'h00;
  localparam logic       RST_ANALOG_SEL_HI    = 1'h0;
  localparam logic [7:0] RST_CONV_CHANNEL_SEL = 8'h00;
  localparam logic       RST_AMP_BIT          = 1'h0;
  localparam logic [2:0] RST_COMPARATOR_EN    = 3'h0;

  // port-7 direction: unused upper bits read as one
  localparam logic [6:0] PORT7_UNUSED_BITS = 7'h7f;

  // field positions
  localparam int POS_AMPLIFIER_ENABLE = 7;
  localparam int POS_GAIN_AMP_ENABLE  = 6;
  localparam int POS_SEL_INTERNAL     = 5;
  localparam int POS_SEL_GAIN_OUT     = 4;
  localparam int POS_SEL_CHAN_HI      = 3;

  // pin numbering: 0..7 are port-2 pins, 8 is the port-7 pin
  localparam int NUM_PINS   = 9;
  localparam int PIN_AMP_N  = 0;
  localparam int PIN_AMP_IO = 1;
  localparam int PIN_AMP_P  = 2;

  // ahb-lite transfer type
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  // routing of every shared pin towards the analog units
  typedef struct packed {
    logic [8:0] conv_pin;   // pin drives the converter input
    logic       conv_gain;  // gain-amplifier output drives the converter
    logic [8:0] analog_in;  // pin held as analog input
    logic [1:0] amp_in;     // pins 0 and 2 feed the amplifier inputs
    logic       amp_out;    // amplifier output drives pin 1
    logic       gain_in;    // pin 1 feeds the gain-amplifier input
    logic [2:0] cmp_in;     // pins 3..5 feed their comparator inputs
  } apfs_route_t;

endpackage

// File: src/apfs_pin_mux.sv
// apfs_pin_mux: direction and function selection for the nine pins shared
// between digital i/o and the analog converter, amplifier and comparators.
// assumes a single ahb-lite master on hclk; pin inputs are asynchronous.
//
// What this block does
// - on a digital pin, each port-2 direction bit set to 0 turns that pin's output buffer on and 1 turns it off.
// - bit 0 of the port-7 direction register turns the digital port-7 output buffer on at 0, off at 1.
// - the port-2 direction register is read/write at its own address and resets to all ones.
// - the port-7 direction register is read/write at its own address and resets to all ones.
// - an analog input-mode pin goes to the converter when the channel select picks it, save pin 1 with only the gain amplifier on.
// - an analog input-mode pin not picked stays analog with no conversion and no digital use.
// - pins 0 and 2 in analog input mode also feed the amplifier when it is enabled.
// - amplifier off and gain amplifier on makes pin 1 the gain input, converted via its output.
// - amplifier on and gain amplifier off puts the amplifier output on pin 1.
// - both on puts the amplifier output on pin 1 and feeds it to the gain amplifier too.
// - pins 3 to 5 in analog input mode feed their comparator when that one is enabled.
// - each digital/analog selection bit means analog at 0, digital at 1, and resets to 0.
`timescale 1ns/1ps
`default_nettype none

module apfs_pin_mux
  import apfs_pkg::*;
(
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // pins
  input  wire logic [8:0]  pin_i,
  output logic [8:0]       pin_o,
  output logic [8:0]       pin_oe,
  // port logic side
  input  wire logic [8:0]  port_out_data,
  output logic [8:0]       port_in_data,
  // analog units side
  output apfs_route_t      route
);

  // register state
  logic [7:0]  port2_direction;
  logic        port7_pin_dir_bit;
  logic [7:0]  analog_pin_select_lo;
  logic        analog_pin_select_hi;
  logic [7:0]  conv_channel_select;
  logic        amplifier_enable;
  logic        gain_amp_enable;
  logic [2:0]  comparator_enable;

  // bus state
  logic        wr_pend;
  logic [15:0] wr_idx;
  logic [31:0] next_rdata;

  // pin synchronisers
  logic [8:0]  pin_meta;
  logic [8:0]  pin_sync;

  // derived modes
  logic [8:0]  dir_in;
  logic [8:0]  digital;
  logic [8:0]  analog_in;
  apfs_route_t next_route;
  logic        addr_ok;
  logic        take;
  logic [15:0] addr_idx;

  function automatic logic chan_hit(input logic [7:0] sel, input logic [3:0] ch);
    chan_hit = !sel[POS_SEL_INTERNAL] && !sel[POS_SEL_GAIN_OUT]
               && (sel[POS_SEL_CHAN_HI:0] == ch);
  endfunction

  function automatic logic [31:0] reg_read(input logic [15:0] idx);
    reg_read = 32'h0000_0000;
    unique case (idx)
      IDX_PORT2_DIRECTION:   reg_read = {24'h00_0000, port2_direction};
      IDX_PORT7_DIRECTION:   reg_read = {24'h00_0000, PORT7_UNUSED_BITS,
                                         port7_pin_dir_bit};
      IDX_ANALOG_SEL_LO:     reg_read = {24'h00_0000, analog_pin_select_lo};
      IDX_ANALOG_SEL_HI:     reg_read = {31'h0000_0000, analog_pin_select_hi};
      IDX_CONV_CHANNEL_SEL:  reg_read = {24'h00_0000, conv_channel_select};
      IDX_AMPLIFIER_CONTROL: reg_read = {24'h00_0000, amplifier_enable,
                                         gain_amp_enable, 6'h00};
      IDX_COMPARATOR_ENABLE: reg_read = {29'h0000_0000, comparator_enable};
      IDX_PIN_ROUTE_STATUS:  reg_read = {6'h00, route};
      default:               reg_read = 32'h0000_0000;
    endcase
  endfunction

  // address phase decode
  assign addr_idx = haddr[17:2];
  assign addr_ok  = (haddr[31:18] == 14'h0000) && (haddr[1:0] == 2'h0);
  assign take     = hsel && hready && (htrans == HTRANS_NONSEQ) && addr_ok;

  // slave always ready with an okay answer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'h1;
      hresp     <= 1'h0;
    end else begin
      hreadyout <= 1'h1;
      hresp     <= 1'h0;
    end
  end

  // write pending into the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'h0;
      wr_idx  <= 16'h0000;
    end else begin
      wr_pend <= take && hwrite;
      wr_idx  <= addr_idx;
    end
  end

  // read data forwarded from a write still in its data phase
  always_comb begin
    next_rdata = reg_read(addr_idx);
    if (wr_pend && (wr_idx == addr_idx)) begin
      unique case (addr_idx)
        IDX_PORT2_DIRECTION:   next_rdata = {24'h00_0000, hwdata[7:0]};
        IDX_PORT7_DIRECTION:   next_rdata = {24'h00_0000, PORT7_UNUSED_BITS, hwdata[0]};
        IDX_ANALOG_SEL_LO:     next_rdata = {24'h00_0000, hwdata[7:0]};
        IDX_ANALOG_SEL_HI:     next_rdata = {31'h0000_0000, hwdata[0]};
        IDX_CONV_CHANNEL_SEL:  next_rdata = {24'h00_0000, hwdata[7:0]};
        IDX_AMPLIFIER_CONTROL: next_rdata = {24'h00_0000, hwdata[7:6], 6'h00};
        IDX_COMPARATOR_ENABLE: next_rdata = {29'h0000_0000, hwdata[2:0]};
        default:               next_rdata = reg_read(addr_idx);
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (take && !hwrite) begin
      hrdata <= next_rdata;
    end
  end

  // direction registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port2_direction   <= RST_PORT2_DIRECTION;
      port7_pin_dir_bit <= RST_PORT7_PIN_DIR;
    end else if (wr_pend) begin
      if (wr_idx == IDX_PORT2_DIRECTION) begin
        port2_direction <= hwdata[7:0];
      end
      if (wr_idx == IDX_PORT7_DIRECTION) begin
        port7_pin_dir_bit <= hwdata[0];
      end
    end
  end

  // digital/analog selection registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      analog_pin_select_lo <= RST_ANALOG_SEL_LO;
      analog_pin_select_hi <= RST_ANALOG_SEL_HI;
    end else if (wr_pend) begin
      if (wr_idx == IDX_ANALOG_SEL_LO) begin
        analog_pin_select_lo <= hwdata[7:0];
      end
      if (wr_idx == IDX_ANALOG_SEL_HI) begin
        analog_pin_select_hi <= hwdata[0];
      end
    end
  end

  // channel select, amplifier and comparator enables
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conv_channel_select <= RST_CONV_CHANNEL_SEL;
      amplifier_enable    <= RST_AMP_BIT;
      gain_amp_enable     <= RST_AMP_BIT;
      comparator_enable   <= RST_COMPARATOR_EN;
    end else if (wr_pend) begin
      if (wr_idx == IDX_CONV_CHANNEL_SEL) begin
        conv_channel_select <= hwdata[7:0];
      end
      if (wr_idx == IDX_AMPLIFIER_CONTROL) begin
        amplifier_enable <= hwdata[POS_AMPLIFIER_ENABLE];
        gain_amp_enable  <= hwdata[POS_GAIN_AMP_ENABLE];
      end
      if (wr_idx == IDX_COMPARATOR_ENABLE) begin
        comparator_enable <= hwdata[2:0];
      end
    end
  end

  // two-flop synchroniser on the pin inputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_meta <= 9'h000;
      pin_sync <= 9'h000;
    end else begin
      pin_meta <= pin_i;
      pin_sync <= pin_meta;
    end
  end

  // per-pin modes
  assign dir_in    = {port7_pin_dir_bit, port2_direction};
  assign digital   = {analog_pin_select_hi, analog_pin_select_lo};
  assign analog_in = ~digital & dir_in;

  // analog routing
  always_comb begin
    next_route = '0;
    for (int i = 0; i < NUM_PINS; i++) begin
      next_route.analog_in[i] = analog_in[i];
      next_route.conv_pin[i]  = analog_in[i]
                                && chan_hit(conv_channel_select, 4'(i));
    end
    // pin 1 with only the gain amplifier on is converted through its output
    if (gain_amp_enable && !amplifier_enable) begin
      next_route.conv_pin[PIN_AMP_IO] = 1'h0;
    end
    next_route.conv_gain = gain_amp_enable && analog_in[PIN_AMP_IO]
                           && !conv_channel_select[POS_SEL_INTERNAL]
                           && conv_channel_select[POS_SEL_GAIN_OUT];
    next_route.amp_in[0] = amplifier_enable && analog_in[PIN_AMP_N];
    next_route.amp_in[1] = amplifier_enable && analog_in[PIN_AMP_P];
    next_route.amp_out   = amplifier_enable && analog_in[PIN_AMP_IO];
    next_route.gain_in   = gain_amp_enable && analog_in[PIN_AMP_IO];
    // pin 3 feeds comparator 2, pin 4 comparator 0, pin 5 comparator 1
    next_route.cmp_in[0] = comparator_enable[2] && analog_in[3];
    next_route.cmp_in[1] = comparator_enable[0] && analog_in[4];
    next_route.cmp_in[2] = comparator_enable[1] && analog_in[5];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      route <= '0;
    end else begin
      route <= next_route;
    end
  end

  // digital buffers: output on when direction bit is 0 on a digital pin
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_oe       <= 9'h000;
      pin_o        <= 9'h000;
      port_in_data <= 9'h000;
    end else begin
      pin_oe       <= digital & ~dir_in;
      pin_o        <= port_out_data & digital & ~dir_in;
      port_in_data <= pin_sync & digital & dir_in;
    end
  end

  property p_oe_port2;
    @(posedge hclk) disable iff (!hresetn)
      (digital[3] && !port2_direction[3]) |=> pin_oe[3];
  endproperty
  a_oe_port2: assert property (p_oe_port2) else $error("port-2 buffer off in output mode");

  property p_oe_port7;
    @(posedge hclk) disable iff (!hresetn)
      port7_pin_dir_bit |=> !pin_oe[8];
  endproperty
  a_oe_port7: assert property (p_oe_port7) else $error("port-7 buffer on in input mode");

  property p_p2_write;
    @(posedge hclk) disable iff (!hresetn)
      (wr_pend && wr_idx == IDX_PORT2_DIRECTION) |=> port2_direction == $past(hwdata[7:0]);
  endproperty
  a_p2_write: assert property (p_p2_write) else $error("port-2 direction not written");

  property p_p7_read;
    @(posedge hclk) disable iff (!hresetn)
      (take && !hwrite && addr_idx == IDX_PORT7_DIRECTION) |=> hrdata[7:1] == 7'h7f;
  endproperty
  a_p7_read: assert property (p_p7_read) else $error("port-7 upper bits not one");

  property p_convert;
    @(posedge hclk) disable iff (!hresetn)
      (analog_in[5] && chan_hit(conv_channel_select, 4'h5)) |=> route.conv_pin[5];
  endproperty
  a_convert: assert property (p_convert) else $error("selected analog pin not converted");

  property p_quiet_analog;
    @(posedge hclk) disable iff (!hresetn)
      (analog_in[6] && !chan_hit(conv_channel_select, 4'h6))
        |=> !pin_oe[6] && !port_in_data[6] && !route.conv_pin[6] && route.analog_in[6];
  endproperty
  a_quiet_analog: assert property (p_quiet_analog) else $error("idle analog pin active");

  property p_amp_in;
    @(posedge hclk) disable iff (!hresetn)
      (amplifier_enable && analog_in[PIN_AMP_P]) |=> route.amp_in[1];
  endproperty
  a_amp_in: assert property (p_amp_in) else $error("amplifier input not routed");

  property p_gain_only;
    @(posedge hclk) disable iff (!hresetn)
      (gain_amp_enable && !amplifier_enable && analog_in[PIN_AMP_IO])
        |=> route.gain_in && !route.conv_pin[PIN_AMP_IO] && !route.amp_out;
  endproperty
  a_gain_only: assert property (p_gain_only) else $error("pin 1 not gain input");

  property p_both_amps;
    @(posedge hclk) disable iff (!hresetn)
      (gain_amp_enable && amplifier_enable && analog_in[PIN_AMP_IO])
        |=> route.amp_out && route.gain_in;
  endproperty
  a_both_amps: assert property (p_both_amps) else $error("pin 1 not shared by both amps");

  property p_cmp;
    @(posedge hclk) disable iff (!hresetn)
      (comparator_enable[0] && analog_in[4]) |=> route.cmp_in[1];
  endproperty
  a_cmp: assert property (p_cmp) else $error("comparator input not routed");

  property p_p7_write;
    @(posedge hclk) disable iff (!hresetn)
      (wr_pend && wr_idx == IDX_PORT7_DIRECTION) |=> port7_pin_dir_bit == $past(hwdata[0]);
  endproperty
  a_p7_write: assert property (p_p7_write) else $error("port-7 direction not written");

  property p_amp_only;
    @(posedge hclk) disable iff (!hresetn)
      (amplifier_enable && !gain_amp_enable && analog_in[PIN_AMP_IO])
        |=> route.amp_out && !route.gain_in && !route.conv_gain;
  endproperty
  a_amp_only: assert property (p_amp_only) else $error("pin 1 not amplifier output");

endmodule // apfs_pin_mux

`default_nettype wire

// File: verif/apfs_pin_partner.sv
// apfs_pin_partner: board-side model of the nine shared pins.
// assumes the bench sets the level that outside parts put on pins the block leaves free.
`timescale 1ns/1ps
`default_nettype none

module apfs_pin_partner (
  // from the block
  input  wire logic [8:0] pin_o,
  input  wire logic [8:0] pin_oe,
  // outside world
  input  wire logic [8:0] ext_level,
  // back to the block
  output logic [8:0]      pin_i
);
  // resolved wire level: the block wins where its buffer is on
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext_level);
endmodule // apfs_pin_partner

`default_nettype wire

// File: verif/tb.sv
// tb: register-level tests of the analog port pin function select block.
// assumes one ahb-lite master, the pin partner model, and a 50 ns clock.
`timescale 1ns/1ps
`default_nettype none

module tb;
  import apfs_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [8:0]  pin_i, pin_o, pin_oe, port_out_data, port_in_data, ext_level;
  logic [7:0]  b;
  apfs_route_t route;
  int          n_errors = 0;
  int          checked = 0;

  apfs_pin_mux apfs_pin_mux_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pin_i(pin_i),
    .pin_o(pin_o), .pin_oe(pin_oe), .port_out_data(port_out_data),
    .port_in_data(port_in_data), .route(route)
  );

  apfs_pin_partner apfs_pin_partner_inst (
    .pin_o(pin_o), .pin_oe(pin_oe), .ext_level(ext_level), .pin_i(pin_i)
  );

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one bus phase: wait, bounded, for hready sampled high
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      n_errors++;
      end_sim();
    end
  endtask

  task automatic bus(input logic wr, input logic [15:0] idx, input logic [7:0] wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {14'h0000, idx, 2'b00};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h000000, wd};
    wait_ready();
    rd = hrdata;
  endtask

  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
  endtask

  task automatic rdchk(input logic [15:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    chk(rd, {24'h000000, exp});
  endtask

  // let one more edge carry register changes to the pins and routes
  task automatic settle();
    @(posedge hclk);
    #1;
  endtask

  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  initial begin
    repeat (20000) @(posedge hclk);
    n_errors++;
    end_sim();
  end

  initial begin
    hresetn = 1'b0; hsel = 1'b0; haddr = 32'h00000000; htrans = 2'h0; hwrite = 1'b0;
    hsize = 3'h2; hwdata = 32'h00000000; port_out_data = 9'h1a5; ext_level = 9'h000;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    // reset values
    settle();
    chk(32'(route.analog_in), 32'h000001ff);
    chk(32'(route.conv_pin), 32'h00000001);
    chk(32'(pin_oe), 32'h00000000);
    rdchk(IDX_PORT2_DIRECTION, 8'hff);
    rdchk(IDX_PORT7_DIRECTION, 8'hff);
    rdchk(IDX_ANALOG_SEL_LO, 8'h00);
    rdchk(IDX_ANALOG_SEL_HI, 8'h00);
    chk(32'(hresp), 32'h00000000);
    // route status: conv_pin, conv_gain, analog_in, then amplifier and comparator feeds
    bus(1'b0, IDX_PIN_ROUTE_STATUS, 8'h00);
    chk(rd, {6'h00, 9'h001, 1'b0, 9'h1ff, 7'h00});
    wr(IDX_PIN_ROUTE_STATUS, 8'hff);
    bus(1'b0, IDX_PIN_ROUTE_STATUS, 8'h00);
    chk(rd, {6'h00, 9'h001, 1'b0, 9'h1ff, 7'h00});
    wr(16'hff20, 8'h00);
    rdchk(16'hff20, 8'h00);
    rdchk(IDX_PORT2_DIRECTION, 8'hff);
    $display("test reset done");
    // digital output, one port-2 pin at a time with the port-7 pin also on, with no pin channel selected
    wr(IDX_CONV_CHANNEL_SEL, 8'h20);
    wr(IDX_ANALOG_SEL_LO, 8'hff);
    wr(IDX_ANALOG_SEL_HI, 8'h01);
    wr(IDX_PORT7_DIRECTION, 8'h00);
    rdchk(IDX_PORT7_DIRECTION, 8'hfe);
    for (int n = 0; n < 8; n++) begin
      b = ~(8'h01 << n);
      wr(IDX_PORT2_DIRECTION, b);
      rdchk(IDX_PORT2_DIRECTION, b);
      settle();
      chk(32'(pin_oe), {23'h0, 1'b1, ~b});
      chk(32'(pin_o), {23'h0, 9'h1a5 & {1'b1, ~b}});
    end
    wr(IDX_PORT7_DIRECTION, 8'hff);
    wr(IDX_PORT2_DIRECTION, 8'hc2);
    settle();
    chk(32'(pin_oe), 32'h0000003d);
    $display("test digital output done");
    // digital input through the synchroniser
    wr(IDX_PORT2_DIRECTION, 8'hff);
    @(posedge hclk);
    ext_level <= 9'h15a;
    repeat (3) @(posedge hclk);
    #1;
    chk(32'(port_in_data), 32'h0000015a);
    chk(32'(pin_oe), 32'h00000000);
    $display("test digital input done");
    // analog pins, every pin channel of the converter
    wr(IDX_ANALOG_SEL_LO, 8'h00);
    wr(IDX_ANALOG_SEL_HI, 8'h00);
    for (int ch = 0; ch < 9; ch++) begin
      wr(IDX_CONV_CHANNEL_SEL, 8'(ch));
      settle();
      chk(32'(route.conv_pin), 32'h1 << ch);
      chk(32'(route.conv_gain), 32'h0);
      chk(32'(port_in_data), 32'h0);
      chk(32'(route.analog_in), 32'h000001ff);
    end
    $display("test conversion done");
    // amplifier and gain amplifier on the shared pins
    wr(IDX_CONV_CHANNEL_SEL, 8'h02);
    wr(IDX_AMPLIFIER_CONTROL, 8'h80);
    settle();
    chk(32'(route.amp_in), 32'h3);
    chk(32'(route.conv_pin), 32'h4);
    chk(32'(route.amp_out), 32'h1);
    chk(32'(route.gain_in), 32'h0);
    wr(IDX_AMPLIFIER_CONTROL, 8'h40);
    wr(IDX_CONV_CHANNEL_SEL, 8'h10);
    settle();
    chk(32'(route.gain_in), 32'h1);
    chk(32'(route.amp_out), 32'h0);
    chk(32'(route.amp_in), 32'h0);
    chk(32'(route.conv_gain), 32'h1);
    chk(32'(route.conv_pin), 32'h0);
    wr(IDX_CONV_CHANNEL_SEL, 8'h01);
    settle();
    chk(32'(route.conv_pin), 32'h0);
    chk(32'(route.conv_gain), 32'h0);
    wr(IDX_AMPLIFIER_CONTROL, 8'hc0);
    settle();
    chk(32'(route.amp_out), 32'h1);
    chk(32'(route.gain_in), 32'h1);
    chk(32'(route.conv_pin), 32'h2);
    wr(IDX_CONV_CHANNEL_SEL, 8'h10);
    settle();
    chk(32'(route.conv_gain), 32'h1);
    chk(32'(route.conv_pin), 32'h0);
    $display("test amplifier done");
    // one comparator, then all three, then one comparator pin turned digital
    wr(IDX_AMPLIFIER_CONTROL, 8'h00);
    wr(IDX_COMPARATOR_ENABLE, 8'h01);
    settle();
    chk(32'(route.cmp_in), 32'h2);
    wr(IDX_COMPARATOR_ENABLE, 8'h07);
    settle();
    chk(32'(route.cmp_in), 32'h7);
    wr(IDX_ANALOG_SEL_LO, 8'h10);
    settle();
    chk(32'(route.cmp_in), 32'h5);
    chk(32'(route.analog_in), 32'h000001ef);
    wr(IDX_COMPARATOR_ENABLE, 8'h00);
    settle();
    chk(32'(route.cmp_in), 32'h0);
    $display("test comparator done");
    // reset in mid-run brings back the direction and analog selection defaults
    wr(IDX_PORT2_DIRECTION, 8'hef);
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    settle();
    chk(32'(pin_oe), 32'h00000000);
    chk(32'(route.analog_in), 32'h000001ff);
    rdchk(IDX_PORT2_DIRECTION, 8'hff);
    rdchk(IDX_PORT7_DIRECTION, 8'hff);
    rdchk(IDX_ANALOG_SEL_LO, 8'h00);
    $display("test mid-run reset done");
    end_sim();
  end
endmodule // tb

`default_nettype wire
